/* File: scd_strap_config.sv */
/*
 * Strap configuration decoder: turns selector pins into bit rate, node
 * number, wireless role and channel, with software overrides over an
 * Avalon-MM slave with waitrequest.
 * Assumes straps are steady at reset release and synchronous inputs.
 */
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

`include "scd_regs.svh"

// Summary of operation
// - Three rate pins select 1000 to 20 kbit/s
// - Three node pins give node one to eight
// - Unstrapped pins give 1000 kbit/s, node one
// - High pin reads one, grounded pin zero
// - Role pin: zero server, one client
// - Three channel pins give channel one to eight
// - Role and channel come from pins by default
// - Software may supply bit rate and node
// - Role and channel entries, with pin enables
// - Pin values never overwrite software entries
// - Pins stay reserved until software value valid
module scd_strap_config (
   input  wire logic              i_core_clk,       // System clock, 100 MHz
   input  wire logic              i_rst,            // Synchronous reset, high
   input  wire logic [2:0]        i_rate_sel,       // Bit rate pins, [2] first
   input  wire logic [2:0]        i_node_sel,       // Node pins, [2] first
   input  wire logic              i_role_sel,       // Role pin
   input  wire logic [2:0]        i_chan_sel,       // Channel pins, [2] first
   input  wire logic [7:0]        i_address,        // Avalon byte address
   input  wire logic              i_read,           // Avalon read
   input  wire logic              i_write,          // Avalon write
   input  wire logic [31:0]       i_writedata,      // Avalon write data
   input  wire logic [3:0]        i_byteenable,     // Avalon byte enables
   output logic      [31:0]       o_readdata,       // Avalon read data
   output logic                   o_waitrequest,    // Avalon wait request
   output scd_pkg::scd_rate_t     o_rate_code,      // Active bit rate code
   output logic      [9:0]        o_rate_kbps,      // Active bit rate, kbit/s
   output logic      [6:0]        o_node_id,        // Active node number
   output scd_pkg::scd_role_t     o_role,           // Active wireless role
   output logic      [3:0]        o_channel,        // Active wireless channel
   output logic      [3:0]        o_pins_reserved,  // Rate, node, role, chan
   output logic                   o_cfg_ready       // Straps caught
);
   import scd_pkg::*;

   // ========================================================================
   // Strap capture
   // ========================================================================
   logic [2:0] strap_rate;
   logic [2:0] strap_node;
   logic [0:0] strap_role;
   logic [2:0] strap_chan;
   logic [3:0] strap_done;

   scd_strap_sampler #(.W(3)) u_rate (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pins     (i_rate_sel),
      .o_code     (strap_rate),
      .o_done     (strap_done[0])
   );
   scd_strap_sampler #(.W(3)) u_node (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pins     (i_node_sel),
      .o_code     (strap_node),
      .o_done     (strap_done[1])
   );
   scd_strap_sampler #(.W(1)) u_role (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pins     (i_role_sel),
      .o_code     (strap_role),
      .o_done     (strap_done[2])
   );
   scd_strap_sampler #(.W(3)) u_chan (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pins     (i_chan_sel),
      .o_code     (strap_chan),
      .o_done     (strap_done[3])
   );

   // ========================================================================
   // Bus handshake
   // ========================================================================
   scd_bus_st_t bus_st_r;
   logic        wr_go;
   logic        wr_lo;
   logic        wr_hi;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bus_st_r      <= SCD_BUS_IDLE;
         o_waitrequest <= 1'b1;
      end else begin
         case (bus_st_r)
            SCD_BUS_IDLE: begin
               if (i_read || i_write) begin
                  bus_st_r      <= SCD_BUS_ACK;
                  o_waitrequest <= 1'b0;
               end
            end
            SCD_BUS_ACK: begin
               bus_st_r      <= SCD_BUS_IDLE;
               o_waitrequest <= 1'b1;
            end
            default: begin
               bus_st_r      <= SCD_BUS_IDLE;
               o_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   assign wr_go = i_write && (bus_st_r == SCD_BUS_ACK);
   assign wr_lo = wr_go && i_byteenable[0];
   assign wr_hi = wr_go && i_byteenable[1];

   // ========================================================================
   // Software entries: node and bit rate
   // ========================================================================
   logic [6:0] od_node_r;
   logic       od_node_ok_r;
   logic [2:0] od_rate_r;
   logic       od_rate_ok_r;
   logic [6:0] wr_node;

   assign wr_node = i_writedata[`SCD_NODE_MSB:`SCD_NODE_LSB];

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         od_node_r    <= `SCD_NODE_RST;
         od_node_ok_r <= 1'b0;
      end else if (wr_lo && i_address == `SCD_OFS_NODE) begin
         od_node_r    <= wr_node;
         od_node_ok_r <= (wr_node != 7'h00) && (wr_node <= `SCD_NODE_MAX);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         od_rate_r    <= 3'h0;
         od_rate_ok_r <= 1'b0;
      end else if (wr_lo && i_address == `SCD_OFS_RATE) begin
         od_rate_r    <= i_writedata[`SCD_RATE_MSB:`SCD_RATE_LSB];
         od_rate_ok_r <= 1'b1;
      end
   end

   // ========================================================================
   // Software entries: wireless role and channel with pin enables
   // ========================================================================
   logic       od_role_r;
   logic       od_role_ok_r;
   logic       role_pin_en_r;
   logic [3:0] od_chan_r;
   logic       od_chan_ok_r;
   logic       chan_pin_en_r;
   logic [3:0] wr_chan;

   assign wr_chan = i_writedata[`SCD_CHAN_MSB:`SCD_CHAN_LSB];

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         od_role_r     <= 1'b0;
         od_role_ok_r  <= 1'b0;
         role_pin_en_r <= `SCD_PIN_EN_RST;
      end else if (i_address == `SCD_OFS_ROLE) begin
         if (wr_lo) begin
            od_role_r    <= i_writedata[`SCD_ROLE_BIT];
            od_role_ok_r <= 1'b1;
         end
         if (wr_hi) begin
            role_pin_en_r <= i_writedata[`SCD_PIN_EN_BIT];
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         od_chan_r     <= `SCD_CHAN_RST;
         od_chan_ok_r  <= 1'b0;
         chan_pin_en_r <= `SCD_PIN_EN_RST;
      end else if (i_address == `SCD_OFS_CHAN) begin
         if (wr_lo) begin
            od_chan_r    <= wr_chan;
            od_chan_ok_r <= (wr_chan != 4'h0) && (wr_chan <= `SCD_CHAN_MAX);
         end
         if (wr_hi) begin
            chan_pin_en_r <= i_writedata[`SCD_PIN_EN_BIT];
         end
      end
   end

   // ========================================================================
   // Active configuration
   // ========================================================================
   logic [2:0] rate_nxt;
   logic       chan_use_od;

   assign rate_nxt    = od_rate_ok_r ? od_rate_r : strap_rate;
   assign chan_use_od = !chan_pin_en_r && od_chan_ok_r;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rate_code <= SCD_RATE_1000;
         o_node_id   <= `SCD_NODE_RST;
         o_role      <= SCD_ROLE_SERVER;
         o_channel   <= `SCD_CHAN_RST;
         o_cfg_ready <= 1'b0;
      end else begin
         o_rate_code <= scd_rate_t'(rate_nxt);
         o_node_id   <= od_node_ok_r ? od_node_r
                                     : {4'h0, strap_node} + 7'h01;
         o_role      <= scd_role_t'(role_pin_en_r ? strap_role[0]
                                                  : od_role_r);
         o_channel   <= chan_use_od ? od_chan_r
                                    : {1'b0, strap_chan} + 4'h1;
         o_cfg_ready <= &strap_done;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rate_kbps <= `SCD_KBPS_0;
      end else begin
         case (rate_nxt)
            3'h0:    o_rate_kbps <= `SCD_KBPS_0;
            3'h1:    o_rate_kbps <= `SCD_KBPS_1;
            3'h2:    o_rate_kbps <= `SCD_KBPS_2;
            3'h3:    o_rate_kbps <= `SCD_KBPS_3;
            3'h4:    o_rate_kbps <= `SCD_KBPS_4;
            3'h5:    o_rate_kbps <= `SCD_KBPS_5;
            3'h6:    o_rate_kbps <= `SCD_KBPS_6;
            default: o_rate_kbps <= `SCD_KBPS_7;
         endcase
      end
   end

   // Pins free for other use only once software holds a valid value
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_pins_reserved <= 4'hf;
      end else begin
         o_pins_reserved <= {!od_chan_ok_r, !od_role_ok_r,
                             !od_node_ok_r, !od_rate_ok_r};
      end
   end

   // ========================================================================
   // Read data
   // ========================================================================
   logic [31:0] rd_nxt;

   // Entries read back their own contents, never the strap values
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (i_address)
         `SCD_OFS_NODE: begin
            rd_nxt[`SCD_NODE_MSB:`SCD_NODE_LSB] = od_node_r;
            rd_nxt[`SCD_VALID_BIT]              = od_node_ok_r;
         end
         `SCD_OFS_RATE: begin
            rd_nxt[`SCD_RATE_MSB:`SCD_RATE_LSB] = od_rate_r;
            rd_nxt[`SCD_VALID_BIT]              = od_rate_ok_r;
         end
         `SCD_OFS_ROLE: begin
            rd_nxt[`SCD_ROLE_BIT]   = od_role_r;
            rd_nxt[`SCD_PIN_EN_BIT] = role_pin_en_r;
            rd_nxt[`SCD_VALID_BIT]  = od_role_ok_r;
         end
         `SCD_OFS_CHAN: begin
            rd_nxt[`SCD_CHAN_MSB:`SCD_CHAN_LSB] = od_chan_r;
            rd_nxt[`SCD_PIN_EN_BIT]             = chan_pin_en_r;
            rd_nxt[`SCD_VALID_BIT]              = od_chan_ok_r;
         end
         `SCD_OFS_STRAP: begin
            rd_nxt[`SCD_STRAP_RATE_LSB +: 3] = strap_rate;
            rd_nxt[`SCD_STRAP_NODE_LSB +: 3] = strap_node;
            rd_nxt[`SCD_STRAP_ROLE_BIT]      = strap_role[0];
            rd_nxt[`SCD_STRAP_CHAN_LSB +: 3] = strap_chan;
            rd_nxt[`SCD_STRAP_DONE_BIT]      = &strap_done;
         end
         `SCD_OFS_ACTIVE: begin
            rd_nxt[`SCD_ACT_NODE_LSB +: 7]  = o_node_id;
            rd_nxt[`SCD_ACT_RATE_LSB +: 3]  = o_rate_code;
            rd_nxt[`SCD_ACT_ROLE_BIT]       = o_role;
            rd_nxt[`SCD_ACT_CHAN_LSB +: 4]  = o_channel;
            rd_nxt[`SCD_ACT_KBPS_LSB +: 10] = o_rate_kbps;
         end
         `SCD_OFS_RESERVE: begin
            rd_nxt[3:0] = o_pins_reserved;
         end
         default: begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_readdata <= 32'h0000_0000;
      end else if (bus_st_r == SCD_BUS_IDLE && i_read) begin
         o_readdata <= rd_nxt;
      end
   end

endmodule

`default_nettype wire

/* File: scd_regs.svh */
/*
 * Register map, field positions, reset values and rate table of the
 * strap configuration decoder.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define SCD_OFS_NODE        8'h00
`define SCD_OFS_RATE        8'h04
`define SCD_OFS_ROLE        8'h08
`define SCD_OFS_CHAN        8'h0c
`define SCD_OFS_STRAP       8'h10
`define SCD_OFS_ACTIVE      8'h14
`define SCD_OFS_RESERVE     8'h18

// ==========================================================================
// Field positions
// ==========================================================================
`define SCD_NODE_LSB        0
`define SCD_NODE_MSB        6
`define SCD_RATE_LSB        0
`define SCD_RATE_MSB        2
`define SCD_ROLE_BIT        0
`define SCD_CHAN_LSB        0
`define SCD_CHAN_MSB        3
`define SCD_PIN_EN_BIT      8
`define SCD_VALID_BIT       31
`define SCD_ACT_NODE_LSB    0
`define SCD_ACT_RATE_LSB    8
`define SCD_ACT_ROLE_BIT    12
`define SCD_ACT_CHAN_LSB    16
`define SCD_ACT_KBPS_LSB    20
`define SCD_STRAP_RATE_LSB  0
`define SCD_STRAP_NODE_LSB  4
`define SCD_STRAP_ROLE_BIT  8
`define SCD_STRAP_CHAN_LSB  12
`define SCD_STRAP_DONE_BIT  31

// ==========================================================================
// Reset values and limits
// ==========================================================================
`define SCD_NODE_RST        7'h01
`define SCD_NODE_MAX        7'h7f
`define SCD_CHAN_RST        4'h1
`define SCD_CHAN_MAX        4'h8
`define SCD_PIN_EN_RST      1'b1

// ==========================================================================
// Bit rate table in kbit/s
// ==========================================================================
`define SCD_KBPS_0          10'h3e8
`define SCD_KBPS_1          10'h320
`define SCD_KBPS_2          10'h1f4
`define SCD_KBPS_3          10'h0fa
`define SCD_KBPS_4          10'h07d
`define SCD_KBPS_5          10'h064
`define SCD_KBPS_6          10'h032
`define SCD_KBPS_7          10'h014

`endif

/* File: scd_pkg.sv */
/*
 * Types shared by the strap configuration decoder.
 * Assumes nothing of its surroundings.
 */
package scd_pkg;

   typedef enum logic [2:0] {
      SCD_RATE_1000 = 3'b000,
      SCD_RATE_800  = 3'b001,
      SCD_RATE_500  = 3'b010,
      SCD_RATE_250  = 3'b011,
      SCD_RATE_125  = 3'b100,
      SCD_RATE_100  = 3'b101,
      SCD_RATE_50   = 3'b110,
      SCD_RATE_20   = 3'b111
   } scd_rate_t;

   typedef enum logic {
      SCD_ROLE_SERVER = 1'b0,
      SCD_ROLE_CLIENT = 1'b1
   } scd_role_t;

   typedef enum logic {
      SCD_BUS_IDLE = 1'b0,
      SCD_BUS_ACK  = 1'b1
   } scd_bus_st_t;

endpackage

/* File: scd_strap_sampler.sv */
/*
 * One group of selector pins, caught once after reset release.
 * Assumes the pins are static and synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none

module scd_strap_sampler #(
   parameter int W = 3
) (
   input  wire logic         i_core_clk,  // System clock
   input  wire logic         i_rst,       // Synchronous reset, high
   input  wire logic [W-1:0] i_pins,      // Selector pins, first pin MSB
   output logic      [W-1:0] o_code,      // Held code
   output logic              o_done       // Code has been caught
);

   // ========================================================================
   // Capture once, then hold
   // ========================================================================
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_code <= '0;
         o_done <= 1'b0;
      end else if (!o_done) begin
         o_code <= i_pins;
         o_done <= 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: scd_jumper_model.sv */
/* Jumper model for the selector pins of the strap decoder.
   Assumes the bench fits jumpers while the device is held in reset. */
`timescale 1ns/100ps
`default_nettype none
module scd_jumper_model (
   input  wire logic [9:0] i_fit,    // Jumper fitted per pin
   input  wire logic [9:0] i_level,  // 1 = tied to supply, 0 = ground
   output logic      [9:0] o_pins    // Levels seen by the device
);
   // Open pins fall to the pull-down level
   assign o_pins = i_fit & i_level;
endmodule
`default_nettype wire

/* File: scd_strap_config_sva.sv */
/* Checker on the top ports of the strap decoder, bound below.
   Assumes straps are caught at the first edge after reset release. */
`timescale 1ns/100ps
`default_nettype none
module scd_strap_config_sva (
   input wire logic               i_core_clk,      // Clock
   input wire logic               i_rst,           // Reset
   input wire logic [2:0]         i_rate_sel,      // Rate pins
   input wire logic [2:0]         i_node_sel,      // Node pins
   input wire logic               i_role_sel,      // Role pin
   input wire logic [2:0]         i_chan_sel,      // Channel pins
   input wire logic               i_read,          // Bus read
   input wire logic               i_write,         // Bus write
   input wire logic               o_waitrequest,   // Bus wait
   input wire scd_pkg::scd_rate_t o_rate_code,     // Rate code
   input wire logic [9:0]         o_rate_kbps,     // Rate kbit/s
   input wire logic [6:0]         o_node_id,       // Node
   input wire scd_pkg::scd_role_t o_role,          // Role
   input wire logic [3:0]         o_channel,       // Channel
   input wire logic [3:0]         o_pins_reserved, // Reserved pins
   input wire logic               o_cfg_ready      // Straps caught
);
   import scd_pkg::*;
   localparam logic [9:0] KBPS [8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa,
                                       10'h07d, 10'h064, 10'h032, 10'h014};
   logic       took_r;
   logic [9:0] cap_r;
   // ==========
   // Straps as caught after release
   always_ff @(posedge i_core_clk) begin
      took_r <= !i_rst;
      if (!i_rst && !took_r) begin
         cap_r <= {i_rate_sel, i_node_sel, i_role_sel, i_chan_sel};
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_req; (i_read || i_write) && o_waitrequest; endsequence
   sequence s_ack; ##1 !o_waitrequest ##1 o_waitrequest; endsequence
   property p_wait; s_req |-> s_ack; endproperty
   a_wait: assert property (p_wait) else $error("bus answer not one cycle");
   property p_kbps; o_rate_kbps == KBPS[o_rate_code]; endproperty
   a_kbps: assert property (p_kbps) else $error("kbps does not match code");
   property p_rate; o_cfg_ready && o_pins_reserved[0] && $past(o_pins_reserved[0])
      |-> o_rate_code == cap_r[9:7]; endproperty
   a_rate: assert property (p_rate) else $error("rate not from straps");
   property p_node; o_cfg_ready && o_pins_reserved[1] && $past(o_pins_reserved[1])
      |-> o_node_id == {4'h0, cap_r[6:4]} + 7'h01; endproperty
   a_node: assert property (p_node) else $error("node not strap plus one");
   property p_role; o_cfg_ready && o_pins_reserved[2] && $past(o_pins_reserved[2])
      |-> o_role == cap_r[3]; endproperty
   a_role: assert property (p_role) else $error("role not from strap");
   property p_chan; o_cfg_ready && o_pins_reserved[3] && $past(o_pins_reserved[3])
      |-> o_channel == {1'b0, cap_r[2:0]} + 4'h1; endproperty
   a_chan: assert property (p_chan) else $error("channel not strap plus one");
   property p_ready; $fell(i_rst) |-> ##[1:2] o_cfg_ready; endproperty
   a_ready: assert property (p_ready) else $error("straps not caught");
   property p_hold; o_cfg_ready |=> o_cfg_ready; endproperty
   a_hold: assert property (p_hold) else $error("ready dropped");
   property p_resv; (o_pins_reserved & ~$past(o_pins_reserved)) == 4'h0; endproperty
   a_resv: assert property (p_resv) else $error("pin reserved again");
endmodule
bind scd_strap_config scd_strap_config_sva u_sva (.i_core_clk, .i_rst, .i_rate_sel,
   .i_node_sel, .i_role_sel, .i_chan_sel, .i_read, .i_write, .o_waitrequest, .o_rate_code,
   .o_rate_kbps, .o_node_id, .o_role, .o_channel, .o_pins_reserved, .o_cfg_ready);
`default_nettype wire

/* File: scd_strap_config_bench.sv */
/* Bench for the strap decoder: strap table, then software overrides.
   Assumes the jumper model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module scd_strap_config_bench;
   import scd_pkg::*;
   typedef struct packed {logic [9:0] fit, lvl; logic [2:0] rate; logic [9:0] kbps;
                          logic [6:0] node; logic role; logic [3:0] chan;} scd_row_t;
   // Row 0 all pins open; rows 1 to 8 step rate and channel up, node down
   localparam scd_row_t ROWS [9] = '{
      {10'h000, 10'h3ff, 3'h0, 10'h3e8, 7'h01, 1'b0, 4'h1},
      {10'h3ff, 10'h070, 3'h0, 10'h3e8, 7'h08, 1'b0, 4'h1},
      {10'h3ff, 10'h0e9, 3'h1, 10'h320, 7'h07, 1'b1, 4'h2},
      {10'h3ff, 10'h152, 3'h2, 10'h1f4, 7'h06, 1'b0, 4'h3},
      {10'h3ff, 10'h1cb, 3'h3, 10'h0fa, 7'h05, 1'b1, 4'h4},
      {10'h3ff, 10'h234, 3'h4, 10'h07d, 7'h04, 1'b0, 4'h5},
      {10'h3ff, 10'h2ad, 3'h5, 10'h064, 7'h03, 1'b1, 4'h6},
      {10'h3ff, 10'h316, 3'h6, 10'h032, 7'h02, 1'b0, 4'h7},
      {10'h3ff, 10'h38f, 3'h7, 10'h014, 7'h01, 1'b1, 4'h8}};
   logic        i_core_clk;
   logic        i_rst        = 1'b1;
   logic [7:0]  i_address    = 8'h00;
   logic        i_read       = 1'b0;
   logic        i_write      = 1'b0;
   logic [31:0] i_writedata  = 32'h0;
   logic [3:0]  i_byteenable = 4'h0;
   logic [9:0]  fit          = 10'h000;
   logic [9:0]  lvl          = 10'h000;
   wire logic [9:0] pins;
   logic [31:0] o_readdata;
   logic        o_waitrequest, o_cfg_ready;
   scd_rate_t   o_rate_code;
   scd_role_t   o_role;
   logic [9:0]  o_rate_kbps;
   logic [6:0]  o_node_id;
   logic [3:0]  o_channel, o_pins_reserved;
   int          error_cnt    = 0;
   int          n_checks     = 0;
   scd_jumper_model u_jump (.i_fit(fit), .i_level(lvl), .o_pins(pins));
   scd_strap_config u_dut (.i_core_clk, .i_rst, .i_rate_sel(pins[9:7]),
      .i_node_sel(pins[6:4]), .i_role_sel(pins[3]), .i_chan_sel(pins[2:0]), .i_address,
      .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
      .o_rate_code, .o_rate_kbps, .o_node_id, .o_role, .o_channel, .o_pins_reserved,
      .o_cfg_ready);
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // ==========
   // Tasks
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_cfg(input logic [2:0] r, input logic [9:0] k, input logic [6:0] nd,
                          input logic rl, input logic [3:0] ch);
      chk("rate", {29'h0, r}, {29'h0, o_rate_code});
      chk("kbps", {22'h0, k}, {22'h0, o_rate_kbps});
      chk("node", {25'h0, nd}, {25'h0, o_node_id});
      chk("role", {31'h0, rl}, {31'h0, o_role});
      chk("chan", {28'h0, ch}, {28'h0, o_channel});
   endtask
   task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge i_core_clk);
      i_address    <= a;
      i_write      <= wr;
      i_read       <= !wr;
      i_writedata  <= d;
      i_byteenable <= be;
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 20);
      if (o_waitrequest !== 1'b0) begin
         error_cnt++;
         report_and_stop();
      end
      q = o_readdata;
      i_read  <= 1'b0;
      i_write <= 1'b0;
      repeat (2) @(posedge i_core_clk);
   endtask
   task automatic av_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      av_xfer(1'b1, a, d, be, q);
   endtask
   task automatic av_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      av_xfer(1'b0, a, 32'h0, 4'hf, q);
      chk("readdata", e, q);
   endtask
   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
   endtask
   // ==========
   // Sequence
   initial begin
      logic [9:0] p;
      foreach (ROWS[k]) begin
         fit <= ROWS[k].fit;
         lvl <= ROWS[k].lvl;
         do_reset();
         p = ROWS[k].fit & ROWS[k].lvl;
         chk_cfg(ROWS[k].rate, ROWS[k].kbps, ROWS[k].node, ROWS[k].role, ROWS[k].chan);
         chk("reserved", 32'h0000_000f, {28'h0, o_pins_reserved});
         chk("ready", 32'h0000_0001, {31'h0, o_cfg_ready});
         av_chk(8'h10, {1'b1, 16'h0, p[2:0], 3'h0, p[3], 1'b0, p[6:4], 1'b0, p[9:7]});
      end
      // Straps moved after capture are ignored
      lvl <= 10'h3ff;
      repeat (3) @(posedge i_core_clk);
      chk_cfg(3'h7, 10'h014, 7'h01, 1'b1, 4'h8);
      av_chk(8'h00, 32'h0000_0001);
      av_chk(8'h04, 32'h0000_0000);
      av_chk(8'h08, 32'h0000_0100);
      av_chk(8'h0c, 32'h0000_0101);
      av_wr(8'h1c, 32'hffff_ffff, 4'hf);
      av_chk(8'h1c, 32'h0000_0000);
      av_wr(8'h00, 32'h0000_0000, 4'hf);
      av_wr(8'h00, 32'h0000_0025, 4'he);
      chk("node", 32'h0000_0001, {25'h0, o_node_id});
      av_wr(8'h00, 32'h0000_0025, 4'hf);
      av_wr(8'h04, 32'h0000_0003, 4'h1);
      av_wr(8'h0c, 32'h0000_0105, 4'hf);
      chk_cfg(3'h3, 10'h0fa, 7'h25, 1'b1, 4'h8);
      av_chk(8'h00, 32'h8000_0025);
      av_wr(8'h0c, 32'h0000_0006, 4'hf);
      av_wr(8'h08, 32'h0000_0000, 4'hf);
      chk_cfg(3'h3, 10'h0fa, 7'h25, 1'b0, 4'h6);
      chk("reserved", 32'h0000_0000, {28'h0, o_pins_reserved});
      av_chk(8'h18, 32'h0000_0000);
      av_chk(8'h14, {2'h0, 10'h0fa, 4'h6, 3'h0, 1'b0, 1'b0, 3'h3, 1'b0, 7'h25});
      // Mid-run reset drops software entries and catches the moved straps
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      chk_cfg(3'h0, 10'h3e8, 7'h01, 1'b0, 4'h1);
      chk("ready", 32'h0000_0000, {31'h0, o_cfg_ready});
      i_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      chk_cfg(3'h7, 10'h014, 7'h08, 1'b1, 4'h8);
      chk("reserved", 32'h0000_000f, {28'h0, o_pins_reserved});
      av_chk(8'h00, 32'h0000_0001);
      report_and_stop();
   end
endmodule
`default_nettype wire
